// ---- ptoc_top.sv ----
// Module: one pulse-plus-direction output port with stop error reporting
`timescale 1ns/1ps
// Function
// - Continuous mode pulses without count until stopped
// - Independent mode emits exact count then ends
// - Fixed-frequency start or ramped start at rate
// - Search-direction limit while reversing: code 0206
// - Done input late after output: code 0300
// - Errors touch only this port
// - Limit input stops output: 0100 or 0101
module ptoc_top
   import ptoc_pkg::*;
(
   // Clock and reset
   input  wire logic        CLOCK,
   input  wire logic        RST_N,
   input  wire logic        CLK_EN,
   // Register port
   input  wire logic [3:0]  ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [31:0] RDATA,
   // Drive and sensor pins
   input  wire logic        CW_LIMIT,
   input  wire logic        CCW_LIMIT,
   input  wire logic        POS_DONE,
   output logic             PULSE_OUT,
   output logic             DIR_OUT,
   output logic             BUSY
);
   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [2:0] pin_meta_r;
   logic [2:0] pin_sync_r;
   logic       cw_lim;
   logic       ccw_lim;
   logic       done_in;
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         pin_meta_r <= 3'h0;
         pin_sync_r <= 3'h0;
      end else if (CLK_EN) begin
         pin_meta_r <= {POS_DONE, CCW_LIMIT, CW_LIMIT};
         pin_sync_r <= pin_meta_r;
      end
   end
   assign cw_lim  = pin_sync_r[0];
   assign ccw_lim = pin_sync_r[1];
   assign done_in = pin_sync_r[2];

   // ****************************************
   // Registers and engine state
   // ****************************************
   ptoc_state_type state_r, state_nxt;
   logic [31:0] target_r, target_nxt;
   logic [31:0] rate_r, rate_nxt;
   logic [31:0] count_r, count_nxt;
   logic [31:0] monitor_r, monitor_nxt;
   logic [31:0] freq_r, freq_nxt;
   logic [31:0] phase_r, phase_nxt;
   logic [31:0] left_r, left_nxt;
   logic [31:0] wait_r, wait_nxt;
   logic [15:0] err_r, err_nxt;
   logic        ramp_r, ramp_nxt;
   logic        indep_r, indep_nxt;
   logic        dir_r, dir_nxt;
   logic        srch_r, srch_nxt;
   logic        rev_r, rev_nxt;
   logic        pulse_r, pulse_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [32:0] phase_sum;
   logic [32:0] freq_sum;
   logic        search_lim;

   // Search direction limit: CW when dir is 0
   assign search_lim = dir_r ? ccw_lim : cw_lim;
   assign phase_sum  = {1'b0, phase_r} + {1'b0, freq_r};
   assign freq_sum   = {1'b0, freq_r} + {1'b0, rate_r};

   always_comb begin
      state_nxt   = state_r;
      target_nxt  = target_r;
      rate_nxt    = rate_r;
      count_nxt   = count_r;
      monitor_nxt = monitor_r;
      freq_nxt    = freq_r;
      phase_nxt   = phase_r;
      left_nxt    = left_r;
      wait_nxt    = wait_r;
      err_nxt     = err_r;
      ramp_nxt    = ramp_r;
      indep_nxt   = indep_r;
      dir_nxt     = dir_r;
      srch_nxt    = srch_r;
      rev_nxt     = rev_r;
      pulse_nxt   = 1'b0;
      rdata_nxt   = RST_WORD;
      // Register writes
      if (WR) begin
         case (ADDR)
            ADDR_TARGET:  target_nxt  = WDATA;
            ADDR_RATE:    rate_nxt    = WDATA;
            ADDR_COUNT:   count_nxt   = WDATA;
            ADDR_MONITOR: monitor_nxt = WDATA;
            default: ;
         endcase
      end
      if (RD) begin
         case (ADDR)
            ADDR_TARGET:  rdata_nxt = target_r;
            ADDR_RATE:    rdata_nxt = rate_r;
            ADDR_COUNT:   rdata_nxt = count_r;
            ADDR_MONITOR: rdata_nxt = monitor_r;
            ADDR_STATUS:  rdata_nxt = {12'h000, rev_r, dir_r, state_r, err_r};
            ADDR_PRESENT: rdata_nxt = freq_r;
            default:      rdata_nxt = RST_WORD;
         endcase
      end
      case (state_r)
         ST_IDLE: begin
            // A start command latches the mode bits, loads the count and clears the error code
            if (WR && ADDR == ADDR_CMD && WDATA[CMD_START_BIT]) begin
               ramp_nxt  = WDATA[CMD_RAMP_BIT];
               indep_nxt = WDATA[CMD_INDEP_BIT];
               dir_nxt   = WDATA[CMD_DIR_BIT];
               srch_nxt  = WDATA[CMD_SRCH_BIT];
               rev_nxt   = WDATA[CMD_REV_BIT];
               freq_nxt  = WDATA[CMD_RAMP_BIT] ? RST_WORD : target_r;
               phase_nxt = RST_WORD;
               left_nxt  = count_r;
               err_nxt   = ERR_NONE;
               state_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            // Ramp climbs by the rate each cycle, clamped at target
            if (ramp_r && freq_r < target_r) begin
               if (freq_sum[31:0] > target_r || freq_sum[32]) begin
                  freq_nxt = target_r;
               end else begin
                  freq_nxt = freq_sum[31:0];
               end
            end
            if (phase_sum[32] || phase_sum[31:0] >= PHASE_WRAP) begin
               phase_nxt = phase_sum[31:0] - PHASE_WRAP;
               pulse_nxt = 1'b1;
               if (indep_r) begin
                  left_nxt = left_r - 32'h0000_0001;
               end
            end else begin
               phase_nxt = phase_sum[31:0];
            end
            // Errors are kept per port; no shared state leaves this module
            if (srch_r && rev_r && search_lim) begin
               err_nxt   = ERR_REVERSE;
               freq_nxt  = RST_WORD;
               state_nxt = ST_IDLE;
            end else if (cw_lim) begin
               err_nxt   = ERR_CW_LIM;
               freq_nxt  = RST_WORD;
               state_nxt = ST_IDLE;
            end else if (ccw_lim) begin
               err_nxt   = ERR_CCW_LIM;
               freq_nxt  = RST_WORD;
               state_nxt = ST_IDLE;
            end else if (WR && ADDR == ADDR_CMD && WDATA[CMD_STOP_BIT]) begin
               freq_nxt  = RST_WORD;
               state_nxt = ST_IDLE;
            end else if (indep_r && (left_r == RST_WORD ||
                         (pulse_nxt && left_r == 32'h0000_0001))) begin
               freq_nxt  = RST_WORD;
               wait_nxt  = RST_WORD;
               state_nxt = ST_WAIT_DONE;
            end
         end
         ST_WAIT_DONE: begin
            // Drive is expected to answer within the monitor time
            if (done_in) begin
               state_nxt = ST_IDLE;
            end else if (wait_r >= monitor_r) begin
               err_nxt   = ERR_TIMEOUT;
               state_nxt = ST_IDLE;
            end else begin
               wait_nxt = wait_r + 32'h0000_0001;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         state_r   <= ST_IDLE;
         target_r  <= RST_WORD;
         rate_r    <= RST_WORD;
         count_r   <= RST_WORD;
         monitor_r <= RST_MONITOR;
         freq_r    <= RST_WORD;
         phase_r   <= RST_WORD;
         left_r    <= RST_WORD;
         wait_r    <= RST_WORD;
         err_r     <= ERR_NONE;
         ramp_r    <= 1'b0;
         indep_r   <= 1'b0;
         dir_r     <= 1'b0;
         srch_r    <= 1'b0;
         rev_r     <= 1'b0;
         pulse_r   <= 1'b0;
         rdata_r   <= RST_WORD;
      end else if (CLK_EN) begin
         state_r   <= state_nxt;
         target_r  <= target_nxt;
         rate_r    <= rate_nxt;
         count_r   <= count_nxt;
         monitor_r <= monitor_nxt;
         freq_r    <= freq_nxt;
         phase_r   <= phase_nxt;
         left_r    <= left_nxt;
         wait_r    <= wait_nxt;
         err_r     <= err_nxt;
         ramp_r    <= ramp_nxt;
         indep_r   <= indep_nxt;
         dir_r     <= dir_nxt;
         srch_r    <= srch_nxt;
         rev_r     <= rev_nxt;
         pulse_r   <= pulse_nxt;
         rdata_r   <= rdata_nxt;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign RDATA     = rdata_r;
   assign PULSE_OUT = pulse_r;
   assign DIR_OUT   = dir_r;
   assign BUSY      = (state_r != ST_IDLE);
endmodule // ptoc_top

// ---- ptoc_pkg.sv ----
// Package: constants and types for the pulse-train output controller
package ptoc_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [3:0] ADDR_CMD      = 4'h0;
   localparam logic [3:0] ADDR_TARGET   = 4'h1;
   localparam logic [3:0] ADDR_RATE     = 4'h2;
   localparam logic [3:0] ADDR_COUNT    = 4'h3;
   localparam logic [3:0] ADDR_MONITOR  = 4'h4;
   localparam logic [3:0] ADDR_STATUS   = 4'h5;
   localparam logic [3:0] ADDR_PRESENT  = 4'h6;
   // ****************************************
   // Command word fields
   // ****************************************
   localparam int CMD_START_BIT = 0;
   localparam int CMD_RAMP_BIT  = 1;
   localparam int CMD_INDEP_BIT = 2;
   localparam int CMD_DIR_BIT   = 3;
   localparam int CMD_STOP_BIT  = 4;
   localparam int CMD_SRCH_BIT  = 5;
   localparam int CMD_REV_BIT   = 6;
   // ****************************************
   // Error codes and reset values
   // ****************************************
   localparam logic [15:0] ERR_NONE     = 16'h0000;
   localparam logic [15:0] ERR_CW_LIM   = 16'h0100;
   localparam logic [15:0] ERR_CCW_LIM  = 16'h0101;
   localparam logic [15:0] ERR_REVERSE  = 16'h0206;
   localparam logic [15:0] ERR_TIMEOUT  = 16'h0300;
   localparam logic [31:0] RST_WORD     = 32'h0000_0000;
   localparam logic [31:0] RST_MONITOR  = 32'h0000_C350;
   localparam int          CLK_HZ       = 50_000_000;
   // Frequency in Hz accumulates per cycle; phase wraps at the clock rate
   localparam logic [31:0] PHASE_WRAP   = 32'(CLK_HZ);
   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_WAIT_DONE} ptoc_state_type;
endpackage

// ---- ptoc_monitor.sv ----
// Checker for the pulse output port
`timescale 1ns/1ps
module ptoc_monitor
   import ptoc_pkg::*;
(
   // Clock, reset, bus
   input wire logic        CLOCK,
   input wire logic        RST_N,
   input wire logic        CLK_EN,
   input wire logic [3:0]  ADDR,
   input wire logic [31:0] WDATA,
   input wire logic        WR,
   input wire logic        RD,
   input wire logic [31:0] RDATA,
   // Pins
   input wire logic        CW_LIMIT,
   input wire logic        CCW_LIMIT,
   input wire logic        PULSE_OUT,
   input wire logic        DIR_OUT,
   input wire logic        BUSY
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N || !CLK_EN);
   sequence s_start;
      WR && ADDR == ADDR_CMD && WDATA[CMD_START_BIT] && !WDATA[CMD_STOP_BIT] && !BUSY;
   endsequence
   sequence s_stop;
      WR && ADDR == ADDR_CMD && WDATA[CMD_STOP_BIT] && !WDATA[CMD_START_BIT];
   endsequence
   // Six cycles cover the two-stage sync plus one pulse in flight
   sequence s_cw_held;
      CW_LIMIT [*6];
   endsequence
   sequence s_ccw_held;
      CCW_LIMIT [*6];
   endsequence
   chk_start_busy: assert property (s_start |=> BUSY)
      else $error("start did not raise BUSY");
   chk_stop_idle: assert property (s_stop |=> !BUSY)
      else $error("stop did not idle");
   chk_cw_halt: assert property (s_cw_held |-> !PULSE_OUT)
      else $error("pulses under CW limit");
   chk_ccw_halt: assert property (s_ccw_held |-> !PULSE_OUT)
      else $error("pulses under CCW limit");
   chk_idle_quiet: assert property (!BUSY && $past(!BUSY) |-> !PULSE_OUT)
      else $error("pulse while idle");
   chk_dir_hold: assert property (BUSY && $past(BUSY) |-> $stable(DIR_OUT))
      else $error("direction moved in motion");
   chk_rdata_zero: assert property (!$past(RD) |-> RDATA == 32'h0)
      else $error("read data outside read slot");
   chk_cmd_reads: assert property (RD && ADDR == ADDR_CMD |=> RDATA == 32'h0)
      else $error("command word readable");
endmodule // ptoc_monitor

// ---- ptoc_drive_model.sv ----
// Behavioural drive: counts pulses, answers positioning done
`timescale 1ns/1ps
module ptoc_drive_model (
   // Port side
   input  wire logic       clock,
   input  wire logic       pulse_in,
   input  wire logic       busy_in,
   // Knobs
   input  wire logic       answer_en,
   input  wire logic [7:0] settle,
   // Answers
   output logic            pos_done,
   output logic [15:0]     pulse_cnt
);
   logic [7:0] quiet_r = 8'h00;
   initial pos_done = 1'b0;
   initial pulse_cnt = 16'h0000;
   always @(posedge clock) begin
      pulse_cnt <= pulse_cnt + 16'(pulse_in);
      quiet_r <= (pulse_in || !busy_in) ? 8'h00 : quiet_r + 8'(quiet_r != 8'hFF);
      // Settles well inside the monitor time; silent when told to be
      pos_done <= answer_en && busy_in && quiet_r >= settle;
   end
endmodule // ptoc_drive_model

// ---- tb_top.sv ----
// Self-checking bench for the pulse output port
`timescale 1ns/1ps
module tb_top
   import ptoc_pkg::*;
   ;
   logic        clock, rst_n, wr, rd, cw_lim, ccw_lim, ans_en, pulse, dir, busy, done, d, cen;
   logic [3:0]  addr;
   logic [31:0] wdata, rdata, v;
   logic [15:0] pcnt, p0;
   logic [15:0] codes [3] = '{ERR_CW_LIM, ERR_CCW_LIM, ERR_REVERSE};
   int          err_total, n_checks, seed, n, cyc, i;
   ptoc_top dut (.CLOCK(clock), .RST_N(rst_n), .CLK_EN(cen), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .CW_LIMIT(cw_lim), .CCW_LIMIT(ccw_lim), .POS_DONE(done), .PULSE_OUT(pulse),
      .DIR_OUT(dir), .BUSY(busy));
   ptoc_drive_model drv (.clock(clock), .pulse_in(pulse), .busy_in(busy), .answer_en(ans_en),
      .settle(8'h08), .pos_done(done), .pulse_cnt(pcnt));
   function automatic logic [31:0] stat(input logic [15:0] c, input logic dd, input logic [1:0] st);
      return {13'h0000, dd, st, c};
   endfunction
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] x);
      @(posedge clock) begin
         addr <= a;
         wdata <= x;
         wr <= 1'b1;
      end
      @(posedge clock) wr <= 1'b0;
      #1;
   endtask
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clock) begin
         addr <= a;
         rd <= 1'b1;
      end
      @(posedge clock) rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wait_idle();
      cyc = 0;
      while (busy !== 1'b0 && cyc < 5000) begin
         @(posedge clock);
         #1;
         cyc++;
      end
      chk("idle", 32'h0, 32'(busy));
   endtask
   task automatic wrap_up();
      if (err_total == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   initial begin
      repeat (20000) @(posedge clock);
      err_total++;
      wrap_up();
   end
   initial begin
      seed = 55887;
      {err_total, n_checks} = 0;
      {rst_n, wr, rd, cw_lim, ccw_lim, addr, wdata} = 0;
      ans_en = 1'b1;
      cen = 1'b1;
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      rd_reg(ADDR_STATUS);
      chk("status", RST_WORD, v);
      rd_reg(ADDR_MONITOR);
      chk("monitor", RST_MONITOR, v);
      rd_reg(4'hF);
      chk("unmapped", 32'h0, v);
      rd_reg(ADDR_CMD);
      chk("cmd read", 32'h0, v);
      wr_reg(ADDR_TARGET, 32'h017D_7840);
      for (i = 0; i < 3; i++) begin
         n = 1 + ($unsigned($random(seed)) % 8);
         d = $random(seed);
         p0 = pcnt;
         wr_reg(ADDR_COUNT, 32'(n));
         wr_reg(ADDR_CMD, 32'h5 | (32'(d) << 3));
         wait_idle();
         chk("pulses", 32'(n), 32'(pcnt - p0));
         chk("dir", 32'(d), 32'(dir));
         rd_reg(ADDR_STATUS);
         chk("status", stat(ERR_NONE, d, 2'h0), v);
      end
      ans_en <= 1'b0;
      wr_reg(ADDR_MONITOR, 32'h28);
      wr_reg(ADDR_COUNT, 32'h2);
      wr_reg(ADDR_CMD, 32'h5);
      wait_idle();
      chk("late", 32'h1, 32'(cyc > 40 && cyc < 60));
      rd_reg(ADDR_STATUS);
      chk("status", stat(ERR_TIMEOUT, 1'b0, 2'h0), v);
      ans_en <= 1'b1;
      p0 = pcnt;
      wr_reg(ADDR_CMD, 32'h1);
      repeat (200) @(posedge clock);
      rd_reg(ADDR_STATUS);
      chk("status", stat(ERR_NONE, 1'b0, 2'h1), v);
      rd_reg(ADDR_PRESENT);
      chk("present", 32'h017D_7840, v);
      // Odd freeze length: a running pulse train would show the other level
      @(posedge clock) cen <= 1'b0;
      repeat (2) @(posedge clock);
      #1 d = pulse;
      repeat (21) @(posedge clock);
      #1 chk("frozen pulse", 32'(d), 32'(pulse));
      chk("frozen busy", 32'h1, 32'(busy));
      @(posedge clock) cen <= 1'b1;
      wr_reg(ADDR_CMD, 32'h10);
      chk("pulses", 32'h1, 32'(16'(pcnt - p0) > 16'h0064));
      chk("busy", 32'h0, 32'(busy));
      for (i = 0; i < 3; i++) begin
         wr_reg(ADDR_CMD, i == 0 ? 32'h1 : i == 1 ? 32'h9 : 32'h61);
         repeat (20) @(posedge clock);
         cw_lim <= (i != 1);
         ccw_lim <= (i == 1);
         wait_idle();
         rd_reg(ADDR_STATUS);
         chk("stop code", stat(codes[i], i == 1, 2'h0), v & 32'h0007_FFFF);
         repeat (3) @(posedge clock);
         cw_lim <= 1'b0;
         ccw_lim <= 1'b0;
         repeat (4) @(posedge clock);
      end
      wr_reg(ADDR_TARGET, 32'h000F_4240);
      wr_reg(ADDR_RATE, 32'h0000_03E8);
      wr_reg(ADDR_CMD, 32'h3);
      rd_reg(ADDR_PRESENT);
      chk("ramping", 32'h1, 32'(v < 32'h000F_4240 && v > 32'h0));
      repeat (1100) @(posedge clock);
      rd_reg(ADDR_PRESENT);
      chk("present", 32'h000F_4240, v);
      wr_reg(ADDR_CMD, 32'h10);
      wrap_up();
   end
endmodule // tb_top
bind ptoc_top ptoc_monitor mon (.CLOCK(CLOCK), .RST_N(RST_N), .CLK_EN(CLK_EN), .ADDR(ADDR), .WDATA(WDATA),
   .WR(WR), .RD(RD), .RDATA(RDATA), .CW_LIMIT(CW_LIMIT), .CCW_LIMIT(CCW_LIMIT), .PULSE_OUT(PULSE_OUT),
   .DIR_OUT(DIR_OUT), .BUSY(BUSY));
